/* File: usc_top.sv */
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Config bit 7 enables eye-pattern test
// - Bit 6 makes output-enable mark driving intervals
// - External transceiver keeps output-enable monitoring active
// - Bit 4 pull-up: D+ full, D- low speed
// - Pull-up ignored with external transceiver
// - Bit 3 selects external transceiver interface
// - Bit 2 selects full or low speed
// - Two-bit field selects ping-pong buffering scheme
// - Driver codes SE0, diff0, diff1; never 11
// - Decode single-ended receive pair into states
// - Output-enable low while transmitting with monitoring active, else high
// - Monitoring active if external or bit 6
// - Eye test repeats J-K or K-J forever
// - Supply pin live with regulator and module enabled
// - Status window shows head of four-entry FIFO
// - Completions push status; extras queue up to four, further ones are dropped
// - Clearing flag pops; flag returns within 5 Tcy
// - Request with full FIFO gets automatic NAK
// - Window: endpoint 6-3, direction 2, bank 1
module usc_top (
	// APB
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Engine side
	input  wire logic                 eng_tx_en,
	input  wire logic [1:0]           eng_tx_code,
	input  wire logic                 xfer_done,
	input  wire usc_pkg::usc_xfer_s   xfer_status,
	input  wire logic                 token_req,
	output logic                      token_nak,
	output usc_pkg::usc_rx_state_e    eng_rx_state,
	output logic                      eng_rx_data,
	output logic                      pp_ep0_out,
	output logic                      pp_ep0_in,
	output logic                      pp_ep_other,
	output logic                      full_speed_sel,
	output logic                      eye_active,
	output logic                      status_fifo_full,
	// Internal transceiver
	input  wire logic                 int_rx_dplus,
	input  wire logic                 int_rx_dminus,
	input  wire logic                 int_rx_diff,
	output logic                      int_tx_plus,
	output logic                      int_tx_minus,
	output logic                      int_tx_en,
	output logic                      int_xcvr_active,
	output logic                      pullup_dplus,
	output logic                      pullup_dminus,
	output logic                      usb_supply_en,
	// External transceiver
	input  wire logic                 rx_single_dplus,
	input  wire logic                 rx_single_dminus,
	input  wire logic                 rx_differential,
	output logic                      tx_drive_plus,
	output logic                      tx_drive_minus,
	output logic                      xcvr_output_enable_n
);

	function automatic logic pp_on(input logic [1:0] mode, input logic ep0, input logic dir_in);
		pp_on = (mode == usc_pkg::PP_ALL) || (mode == usc_pkg::PP_EP1_15 && !ep0)
			|| (mode == usc_pkg::PP_EP0_OUT && ep0 && !dir_in);
	endfunction

	// Registers
	logic [7:0]                     usb_configuration;
	logic                           module_enable;
	logic                           regulator_enable;
	logic                           transfer_done_flag;
	usc_pkg::usc_xfer_s             fifo_mem [usc_pkg::FIFO_DEPTH];
	logic [usc_pkg::PTR_W-1:0]      rd_ptr;
	logic [usc_pkg::PTR_W-1:0]      wr_ptr;
	logic [usc_pkg::CNT_W-1:0]      fifo_cnt;
	logic [usc_pkg::BITCNT_W-1:0]   bit_cnt;
	logic                           eye_phase;
	logic [5:0]                     rx_sync1;
	logic [5:0]                     rx_sync2;

	// APB decode
	wire apb_access = psel && penable && pready;
	wire apb_write = apb_access && pwrite;
	wire hit_cfg = paddr == usc_pkg::ADDR_CONFIG;
	wire hit_ctl = paddr == usc_pkg::ADDR_CONTROL;
	wire hit_win = paddr == usc_pkg::ADDR_STATUS_WIN;
	wire hit_flg = paddr == usc_pkg::ADDR_FLAGS;
	wire hit_any = hit_cfg || hit_ctl || hit_win || hit_flg;
	wire wr_cfg = apb_write && hit_cfg;
	wire wr_ctl = apb_write && hit_ctl;
	wire clr_done = apb_write && hit_flg && pwdata[usc_pkg::FLG_DONE] && transfer_done_flag;

	// Configuration fields
	wire cfg_eye = usb_configuration[usc_pkg::CFG_EYE];
	wire cfg_oemon = usb_configuration[usc_pkg::CFG_OEMON];
	wire cfg_pullup = usb_configuration[usc_pkg::CFG_PULLUP];
	wire cfg_xdis = usb_configuration[usc_pkg::CFG_XDIS];
	wire cfg_fs = usb_configuration[usc_pkg::CFG_FS];
	wire [1:0] cfg_pp = usb_configuration[usc_pkg::CFG_PP_HI:usc_pkg::CFG_PP_LO];

	// Status FIFO
	wire fifo_full = fifo_cnt == usc_pkg::CNT_FULL;
	wire fifo_empty = fifo_cnt == '0;
	wire push = xfer_done && !fifo_full && module_enable;
	wire pop = clr_done && !fifo_empty;
	usc_pkg::usc_xfer_s head;
	assign head = fifo_mem[rd_ptr];

	wire [usc_pkg::CNT_W-1:0] next_fifo_cnt = !module_enable ? '0 :
		fifo_cnt + usc_pkg::CNT_W'(push) - usc_pkg::CNT_W'(pop);
	// Flag drops for one cycle on a clear, then returns if entries remain
	wire next_done = module_enable && ((transfer_done_flag && !clr_done)
		|| (!transfer_done_flag && !fifo_empty));

	// Window read value
	wire [31:0] win_data = {24'h0, 1'b0, head.endpoint_number, head.dir_in,
		head.pingpong_bank_indicator, 1'b0};
	wire [31:0] flg_data = {27'h0, fifo_cnt, fifo_full, transfer_done_flag};
	wire [31:0] next_prdata = !hit_any ? 32'h0 :
		hit_cfg ? {24'h0, usb_configuration} :
		hit_ctl ? {30'h0, regulator_enable, module_enable} :
		hit_win ? win_data : flg_data;

	// Eye pattern and transmit path
	wire eye_run = cfg_eye && module_enable;
	wire [usc_pkg::BITCNT_W-1:0] bit_last = cfg_fs ?
		usc_pkg::BITCNT_W'(usc_pkg::FS_BIT_CLKS - 1) :
		usc_pkg::BITCNT_W'(usc_pkg::LS_BIT_CLKS - 1);
	wire bit_end = bit_cnt >= bit_last;
	// Low speed J and full speed K are both differential 0, so both sequences open on it
	wire [1:0] eye_code = eye_phase ? usc_pkg::TX_DIFF1 : usc_pkg::TX_DIFF0;
	wire [1:0] eng_code = eng_tx_code == usc_pkg::TX_ILLEGAL ? usc_pkg::TX_SE0 : eng_tx_code;
	wire driving = eye_run || (eng_tx_en && module_enable);
	wire [1:0] next_code = !driving ? usc_pkg::TX_SE0 : eye_run ? eye_code : eng_code;
	wire oe_monitor = cfg_xdis || cfg_oemon;
	wire next_oe_n = !(oe_monitor && driving);

	// Receive path: both pin sets are synchronised, the choice is made after the second stage
	wire [2:0] rx_pick = cfg_xdis ? rx_sync2[5:3] : rx_sync2[2:0];
	usc_pkg::usc_rx_state_e next_rx_state;
	assign next_rx_state = usc_pkg::usc_rx_state_e'(rx_pick[2:1]);

	// Pull-up and supply
	wire pull_ok = module_enable && cfg_pullup && !cfg_xdis;
	wire next_pu_dp = pull_ok && cfg_fs;
	wire next_pu_dm = pull_ok && !cfg_fs;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit_any;
			prdata <= next_prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			usb_configuration <= usc_pkg::CFG_RESET;
			module_enable <= 1'b0;
			regulator_enable <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
				usb_configuration <= pwdata[7:0] & usc_pkg::CFG_WMASK;
			if (wr_ctl)
			begin
				module_enable <= pwdata[usc_pkg::CTL_MODEN];
				regulator_enable <= pwdata[usc_pkg::CTL_REGEN];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fifo_cnt <= '0;
			rd_ptr <= '0;
			wr_ptr <= '0;
			transfer_done_flag <= 1'b0;
			token_nak <= 1'b0;
			status_fifo_full <= 1'b0;
		end
		else
		begin
			fifo_cnt <= next_fifo_cnt;
			rd_ptr <= !module_enable ? '0 : rd_ptr + usc_pkg::PTR_W'(pop);
			wr_ptr <= !module_enable ? '0 : wr_ptr + usc_pkg::PTR_W'(push);
			transfer_done_flag <= next_done;
			token_nak <= token_req && fifo_full && module_enable;
			status_fifo_full <= next_fifo_cnt == usc_pkg::CNT_FULL;
		end
	end

	// Entry storage has no reset; the window shows the entry at rd_ptr whatever the count
	always_ff @(posedge pclk)
	begin
		if (push)
			fifo_mem[wr_ptr] <= xfer_status;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_cnt <= '0;
			eye_phase <= 1'b0;
		end
		else
		begin
			bit_cnt <= (!eye_run || bit_end) ? '0 : bit_cnt + 1'b1;
			eye_phase <= eye_run && (eye_phase ^ bit_end);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_drive_plus <= 1'b0;
			tx_drive_minus <= 1'b0;
			int_tx_plus <= 1'b0;
			int_tx_minus <= 1'b0;
			int_tx_en <= 1'b0;
			xcvr_output_enable_n <= 1'b1;
			eye_active <= 1'b0;
		end
		else
		begin
			{tx_drive_plus, tx_drive_minus} <= cfg_xdis ? next_code : usc_pkg::TX_SE0;
			{int_tx_plus, int_tx_minus} <= cfg_xdis ? usc_pkg::TX_SE0 : next_code;
			int_tx_en <= !cfg_xdis && driving;
			xcvr_output_enable_n <= next_oe_n;
			eye_active <= eye_run;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_sync1 <= 6'h00;
			rx_sync2 <= 6'h00;
			eng_rx_state <= usc_pkg::RX_SE0;
			eng_rx_data <= 1'b0;
		end
		else
		begin
			rx_sync1 <= {rx_single_dplus, rx_single_dminus, rx_differential, int_rx_dplus, int_rx_dminus, int_rx_diff};
			rx_sync2 <= rx_sync1;
			eng_rx_state <= next_rx_state;
			eng_rx_data <= rx_pick[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_xcvr_active <= 1'b0;
			full_speed_sel <= 1'b0;
			pullup_dplus <= 1'b0;
			pullup_dminus <= 1'b0;
			usb_supply_en <= 1'b0;
			pp_ep0_out <= 1'b0;
			pp_ep0_in <= 1'b0;
			pp_ep_other <= 1'b0;
		end
		else
		begin
			int_xcvr_active <= !cfg_xdis;
			full_speed_sel <= cfg_fs;
			pullup_dplus <= next_pu_dp;
			pullup_dminus <= next_pu_dm;
			usb_supply_en <= regulator_enable && module_enable;
			pp_ep0_out <= pp_on(cfg_pp, 1'b1, 1'b0);
			pp_ep0_in <= pp_on(cfg_pp, 1'b1, 1'b1);
			pp_ep_other <= pp_on(cfg_pp, 1'b0, 1'b0);
		end
	end

	chk_drive_never_illegal: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(tx_drive_plus && tx_drive_minus) && !(int_tx_plus && int_tx_minus))
		else $error("driver pair shows the illegal 11 code");

	chk_oe_follows_drive: assert property (
		@(posedge pclk) disable iff (!presetn)
		(oe_monitor && driving) |=> !xcvr_output_enable_n)
		else $error("output enable not low while driving");

	chk_oe_idle_high: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!driving || (!cfg_xdis && !cfg_oemon)) |=> xcvr_output_enable_n)
		else $error("output enable low with nothing driven or monitor off");

	chk_pullup_gated: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(cfg_xdis) |-> !pullup_dplus && !pullup_dminus)
		else $error("pull-up on with external transceiver");

	chk_pullup_side: assert property (
		@(posedge pclk) disable iff (!presetn)
		(module_enable && cfg_pullup && !cfg_xdis) |=> (pullup_dplus == $past(cfg_fs))
			&& (pullup_dminus != $past(cfg_fs)))
		else $error("pull-up on wrong line for speed");

	chk_supply_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		usb_supply_en |-> $past(regulator_enable) && $past(module_enable))
		else $error("supply pin live without both enables");

	chk_flag_returns: assert property (
		@(posedge pclk) disable iff (!presetn)
		(clr_done && fifo_cnt > 3'h1 && module_enable) |-> ##[1:2] transfer_done_flag)
		else $error("flag not back after clear with entries left");

	chk_flag_stays_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		(clr_done && fifo_cnt == 3'h1 && !xfer_done) |=> !transfer_done_flag)
		else $error("flag back with an empty FIFO");

	chk_full_nak: assert property (
		@(posedge pclk) disable iff (!presetn)
		(token_req && fifo_full && module_enable) |=> token_nak)
		else $error("no NAK for request while FIFO full");

	chk_no_overflow: assert property (
		@(posedge pclk) disable iff (!presetn)
		fifo_cnt <= usc_pkg::CNT_FULL)
		else $error("status FIFO count beyond four");

	chk_disable_flush: assert property (
		@(posedge pclk) disable iff (!presetn)
		!module_enable |=> fifo_cnt == 3'h0 && !transfer_done_flag)
		else $error("FIFO not flushed while module disabled");

	chk_eye_alternates: assert property (
		@(posedge pclk) disable iff (!presetn)
		(eye_run && bit_end) ##1 eye_run |-> eye_phase != $past(eye_phase))
		else $error("eye pattern failed to alternate");

	chk_rx_decode: assert property (
		@(posedge pclk) disable iff (!presetn)
		##1 (eng_rx_state == usc_pkg::RX_ERROR) == $past(rx_pick[2] && rx_pick[1]))
		else $error("receive pair decoded wrongly");

endmodule

/* File: usc_pkg.sv */
package usc_pkg;

	// Register byte addresses
	localparam logic [11:0] ADDR_CONFIG = 12'h000;
	localparam logic [11:0] ADDR_CONTROL = 12'h004;
	localparam logic [11:0] ADDR_STATUS_WIN = 12'h008;
	localparam logic [11:0] ADDR_FLAGS = 12'h00C;

	// usb_configuration fields
	localparam int CFG_EYE = 7;
	localparam int CFG_OEMON = 6;
	localparam int CFG_PULLUP = 4;
	localparam int CFG_XDIS = 3;
	localparam int CFG_FS = 2;
	localparam int CFG_PP_HI = 1;
	localparam int CFG_PP_LO = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'hDF;

	// Control register fields
	localparam int CTL_MODEN = 0;
	localparam int CTL_REGEN = 1;

	// Flag register fields
	localparam int FLG_DONE = 0;
	localparam int FLG_FULL = 1;
	localparam int FLG_CNT_LO = 2;

	// Status window fields
	localparam int WIN_EP_LO = 3;
	localparam int WIN_DIR = 2;
	localparam int WIN_BANK = 1;

	// Ping-pong modes
	localparam logic [1:0] PP_NONE = 2'h0;
	localparam logic [1:0] PP_EP0_OUT = 2'h1;
	localparam logic [1:0] PP_ALL = 2'h2;
	localparam logic [1:0] PP_EP1_15 = 2'h3;

	// Driver codes, {plus, minus}
	localparam logic [1:0] TX_SE0 = 2'h0;
	localparam logic [1:0] TX_DIFF0 = 2'h1;
	localparam logic [1:0] TX_DIFF1 = 2'h2;
	localparam logic [1:0] TX_ILLEGAL = 2'h3;

	// Status FIFO
	localparam int FIFO_DEPTH = 4;
	localparam int PTR_W = 2;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] CNT_FULL = 3'h4;

	// Flag must come back within this many instruction cycles of 4 clocks
	localparam int REFLAG_TCY = 5;
	localparam int TCY_CLKS = 4;
	localparam int REFLAG_CLKS = REFLAG_TCY * TCY_CLKS;

	// Eye-pattern bit timing
	localparam int CLK_HZ = 50_000_000;
	localparam int FS_BIT_HZ = 12_000_000;
	localparam int LS_BIT_HZ = 1_500_000;
	localparam int FS_BIT_CLKS = CLK_HZ / FS_BIT_HZ;
	localparam int LS_BIT_CLKS = CLK_HZ / LS_BIT_HZ;
	localparam int BITCNT_W = 6;

	typedef struct packed {
		logic [3:0] endpoint_number;
		logic       dir_in;
		logic       pingpong_bank_indicator;
	} usc_xfer_s;

	typedef enum logic [1:0] {
		RX_SE0,
		RX_LOW_SPEED,
		RX_HIGH_SPEED,
		RX_ERROR
	} usc_rx_state_e;

endpackage

/* File: usc_xcvr_model.sv */
`timescale 1ns/1ps
module usc_xcvr_model (
	// Clock and bus stimulus
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] bus_state,
	// Engine drive
	input  wire logic       tx_drive_plus,
	input  wire logic       tx_drive_minus,
	input  wire logic       xcvr_output_enable_n,
	// Receive towards the engine
	output logic            rx_single_dplus,
	output logic            rx_single_dminus,
	output logic            rx_differential,
	output logic            illegal_seen
);
	// While the engine drives, the lines echo its code, else the host state
	wire logic [1:0] line_state = xcvr_output_enable_n ? bus_state : {tx_drive_plus, tx_drive_minus};

	assign {rx_single_dplus, rx_single_dminus} = line_state;
	assign rx_differential = (line_state == 2'h2);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			illegal_seen <= 1'b0;
		else if ({tx_drive_plus, tx_drive_minus} == 2'h3)
			illegal_seen <= 1'b1;
	end
endmodule

/* File: tb_usb_sie_config_xcvr_status.sv */
`timescale 1ns/1ps
module tb_usb_sie_config_xcvr_status;
	typedef struct packed {logic [7:0] cfg; logic [6:0] exp;} usc_row_s;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, perr, eng_tx_en = 1'b0, xfer_done = 1'b0, token_req = 1'b0;
	logic [1:0] eng_tx_code = 2'h0, bus_state = 2'h0, prev;
	usc_pkg::usc_xfer_s xfer_status = '0;
	usc_pkg::usc_rx_state_e eng_rx_state;
	logic token_nak, eng_rx_data, pp_ep0_out, pp_ep0_in, pp_ep_other, full_speed_sel, eye_active;
	logic status_fifo_full, int_tx_plus, int_tx_minus, int_tx_en, int_xcvr_active;
	logic pullup_dplus, pullup_dminus, usb_supply_en, illegal_seen;
	logic int_rx_dplus = 1'b0, int_rx_dminus = 1'b0, int_rx_diff = 1'b0;
	logic rx_single_dplus, rx_single_dminus, rx_differential, tx_drive_plus, tx_drive_minus;
	logic xcvr_output_enable_n;
	int num_errors = 0, checked = 0, badc, changes;
	logic [7:0] tcfg [3] = '{8'h08, 8'h40, 8'h00};
	logic toe [3] = '{1'b0, 1'b0, 1'b1};
	usc_row_s rows [5] = '{'{8'h13, 7'h15}, '{8'h16, 7'h7E}, '{8'h0D, 7'h48}, '{8'h18, 7'h00}, '{8'h00, 7'h04}};

	usc_top usc_top_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eng_tx_en(eng_tx_en),
		.eng_tx_code(eng_tx_code), .xfer_done(xfer_done), .xfer_status(xfer_status), .token_req(token_req),
		.token_nak(token_nak), .eng_rx_state(eng_rx_state), .eng_rx_data(eng_rx_data), .pp_ep0_out(pp_ep0_out),
		.pp_ep0_in(pp_ep0_in), .pp_ep_other(pp_ep_other), .full_speed_sel(full_speed_sel),
		.eye_active(eye_active), .status_fifo_full(status_fifo_full), .int_rx_dplus(int_rx_dplus),
		.int_rx_dminus(int_rx_dminus), .int_rx_diff(int_rx_diff), .int_tx_plus(int_tx_plus),
		.int_tx_minus(int_tx_minus), .int_tx_en(int_tx_en), .int_xcvr_active(int_xcvr_active),
		.pullup_dplus(pullup_dplus), .pullup_dminus(pullup_dminus), .usb_supply_en(usb_supply_en),
		.rx_single_dplus(rx_single_dplus), .rx_single_dminus(rx_single_dminus),
		.rx_differential(rx_differential), .tx_drive_plus(tx_drive_plus), .tx_drive_minus(tx_drive_minus),
		.xcvr_output_enable_n(xcvr_output_enable_n));
	usc_xcvr_model usc_xcvr_model_i (
		.pclk(pclk), .presetn(presetn), .bus_state(bus_state), .tx_drive_plus(tx_drive_plus),
		.tx_drive_minus(tx_drive_minus), .xcvr_output_enable_n(xcvr_output_enable_n),
		.rx_single_dplus(rx_single_dplus), .rx_single_dminus(rx_single_dminus),
		.rx_differential(rx_differential), .illegal_seen(illegal_seen));

	always #10 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Module is disabled around every configuration change
	task automatic setup_cfg(input logic [7:0] c);
		apb(1'b1, usc_pkg::ADDR_CONTROL, 32'h0);
		apb(1'b1, usc_pkg::ADDR_CONFIG, {24'h0, c});
		apb(1'b1, usc_pkg::ADDR_CONTROL, 32'h1);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask

	task automatic push(input logic [5:0] s);
		@(posedge pclk);
		xfer_done <= 1'b1;
		xfer_status <= s;
		@(posedge pclk);
		xfer_done <= 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		$display("BAD watchdog expected finish seen hang");
		conclude();
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		chk("oe_n reset", xcvr_output_enable_n, 1'b1);
		chk("xcvr active", int_xcvr_active, 1'b1);
		apb(1'b0, usc_pkg::ADDR_CONFIG, 32'h0);
		chk("cfg reset", rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped err", perr, 1'b1);
		chk("unmapped data", rd, 32'h0);
		$display("test reset done");
		foreach (rows[i])
		begin
			setup_cfg(rows[i].cfg | 8'h20);
			apb(1'b0, usc_pkg::ADDR_CONFIG, 32'h0);
			chk("cfg read", rd, {24'h0, rows[i].cfg});
			tick(2);
			chk("cfg outs", {pp_ep0_out, pp_ep0_in, pp_ep_other, full_speed_sel, int_xcvr_active,
				pullup_dplus, pullup_dminus}, rows[i].exp);
		end
		apb(1'b1, usc_pkg::ADDR_CONTROL, 32'h3);
		tick(2);
		chk("supply on", usb_supply_en, 1'b1);
		apb(1'b1, usc_pkg::ADDR_CONTROL, 32'h2);
		tick(2);
		chk("supply off", usb_supply_en, 1'b0);
		$display("test config done");
		for (int t = 0; t < 3; t++)
		begin
			setup_cfg(tcfg[t]);
			for (int c = 0; c < 4; c++)
			begin
				@(posedge pclk);
				eng_tx_en <= 1'b1;
				eng_tx_code <= 2'(c);
				tick(2);
				chk("oe_n drive", xcvr_output_enable_n, toe[t]);
				if (t == 0)
					chk("ext code", {tx_drive_plus, tx_drive_minus}, (c == 3) ? 2'h0 : 2'(c));
				else
					chk("int code", {int_tx_en, int_tx_plus, int_tx_minus}, {1'b1, (c == 3) ? 2'h0 : 2'(c)});
				@(posedge pclk);
				eng_tx_en <= 1'b0;
				tick(2);
				chk("oe_n idle", xcvr_output_enable_n, 1'b1);
			end
		end
		chk("no illegal", illegal_seen, 1'b0);
		for (int x = 0; x < 2; x++)
		begin
			setup_cfg(x ? 8'h00 : 8'h08);
			for (int v = 0; v < 4; v++)
			begin
				// The side not selected carries the opposite state
				@(posedge pclk);
				bus_state <= 2'(x ? 3 - v : v);
				{int_rx_dplus, int_rx_dminus} <= 2'(x ? v : 3 - v);
				int_rx_diff <= x ? (v == 2) : (v != 2);
				tick(4);
				chk("rx state", eng_rx_state, 32'(v));
				chk("rx data", eng_rx_data, v == 2);
			end
		end
		$display("test transceiver done");
		// No host is attached while the eye pattern runs
		setup_cfg(8'h8C);
		tick(4);
		chk("eye on", eye_active, 1'b1);
		badc = 0;
		changes = 0;
		prev = {tx_drive_plus, tx_drive_minus};
		repeat (40)
		begin
			tick(0);
			if ({tx_drive_plus, tx_drive_minus} != 2'h1 && {tx_drive_plus, tx_drive_minus} != 2'h2)
				badc++;
			if ({tx_drive_plus, tx_drive_minus} != prev)
				changes++;
			prev = {tx_drive_plus, tx_drive_minus};
		end
		chk("eye codes", badc, 32'h0);
		chk("eye toggles", changes >= 8, 1'b1);
		chk("eye oe_n", xcvr_output_enable_n, 1'b0);
		setup_cfg(8'h00);
		tick(2);
		chk("eye off", eye_active, 1'b0);
		$display("test eye done");
		for (int i = 1; i < 6; i++)
			push(6'((i << 2) | (i & 3)));
		tick(3);
		chk("fifo full", status_fifo_full, 1'b1);
		apb(1'b0, usc_pkg::ADDR_FLAGS, 32'h0);
		chk("flags full", rd, 32'h13);
		@(posedge pclk);
		token_req <= 1'b1;
		@(posedge pclk);
		token_req <= 1'b0;
		tick(0);
		chk("nak", token_nak, 1'b1);
		for (int k = 1; k < 5; k++)
		begin
			apb(1'b0, usc_pkg::ADDR_STATUS_WIN, 32'h0);
			chk("window", rd, 32'(((k << 2) | (k & 3)) << 1));
			apb(1'b1, usc_pkg::ADDR_FLAGS, 32'h1);
			tick(2);
			apb(1'b0, usc_pkg::ADDR_FLAGS, 32'h0);
			chk("reflag", rd[0], k < 4);
		end
		chk("flags empty", rd, 32'h0);
		@(posedge pclk);
		token_req <= 1'b1;
		@(posedge pclk);
		token_req <= 1'b0;
		tick(0);
		chk("no nak", token_nak, 1'b0);
		push(6'h04);
		tick(3);
		apb(1'b1, usc_pkg::ADDR_CONTROL, 32'h0);
		tick(1);
		apb(1'b0, usc_pkg::ADDR_FLAGS, 32'h0);
		chk("flush", rd, 32'h0);
		$display("test fifo done");
		setup_cfg(8'h16);
		tick(2);
		chk("pull before", pullup_dplus, 1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		chk("pull after", pullup_dplus, 1'b0);
		chk("oe_n after", xcvr_output_enable_n, 1'b1);
		apb(1'b0, usc_pkg::ADDR_CONFIG, 32'h0);
		chk("cfg after", rd, 32'h0);
		apb(1'b0, usc_pkg::ADDR_CONTROL, 32'h0);
		chk("ctl after", rd, 32'h0);
		$display("test reset again done");
		conclude();
	end
endmodule
